//--- rtl/ssg_pkg.sv
// Shared constants and carrier types of the SRAM security gate
package ssg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses within the configuration port)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_LIMIT  = 12'h010;
  localparam logic [11:0] OFS_GEOM   = 12'h014;
  localparam logic [11:0] OFS_INDEX  = 12'h018;
  localparam logic [11:0] OFS_WINDOW = 12'h01c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LOCK = 31;
  localparam int CTRL_AUTO = 8;
  localparam int CTRL_ACK  = 7;
  localparam int CTRL_REQ  = 6;
  localparam int CTRL_RESP = 4;
  localparam int PROT_NS   = 1;

  // ----------------------------------------------------------------
  // Reset values and geometry figures
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] INDEX_RESET    = 32'h0000_0000;
  localparam logic [31:0] LUT_RESET      = 32'h0000_0000;
  localparam logic [31:0] RSP_ZERO       = 32'h0000_0000;
  localparam logic [3:0]  STRB_FULL      = 4'hf;
  localparam int          BLK_SHIFT_BASE = 5;
  localparam int          WORD_LOG       = 5;
  localparam int          AUTO_MARGIN    = 11;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
  } ssg_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ssg_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        nonsec;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ssg_mem_req_t;

  typedef struct packed {
    logic        rvalid;
    logic        err;
    logic [31:0] rdata;
  } ssg_mem_rsp_t;

endpackage

//--- rtl/ssg_lut.sv
// Block attribute lookup table of the SRAM security gate
`timescale 1ns/10ps
`default_nettype none

module ssg_lut #(
  parameter int WORDS = 32,
  parameter int IDX_W = 5,
  parameter int BLK_W = 10
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [31:0]      wr_data,
  input  wire logic [3:0]       wr_strb,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [31:0]      rd_word,
  input  wire logic [BLK_W-1:0] blk_num,
  output logic                  blk_nonsec
);

  typedef struct packed {
    logic [WORDS-1:0][31:0] word;
  } ssg_lut_state_t;

  ssg_lut_state_t         st;
  ssg_lut_state_t         next_st;
  logic [WORDS*32-1:0]    flat;

  // ----------------------------------------------------------------
  // Byte-laned update of the word at the index
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (ce && wr_en)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_strb[b])
        begin
          next_st.word[wr_idx][8*b +: 8] = wr_data[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st <= ssg_lut_state_t'({WORDS{ssg_pkg::LUT_RESET}});
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_word    = st.word[rd_idx];
  assign flat       = st.word;
  // One bit per block, set means non-secure
  assign blk_nonsec = flat[blk_num];

endmodule
`default_nettype wire

//--- rtl/ssg_check.sv
// Memory-side security check of the SRAM security gate
`timescale 1ns/10ps
`default_nettype none

module ssg_check #(
  parameter int ADDR_WIDTH = 15,
  parameter int BLK_BITS   = 5,
  parameter int BLK_W      = 10
) (
  input  wire ssg_pkg::ssg_mem_req_t up_req,
  input  wire logic                  attr_nonsec,
  output logic       [BLK_W-1:0]     blk_num,
  output logic                       violation
);

  // Block number is the address above the block offset
  assign blk_num   = up_req.addr[ADDR_WIDTH-1:BLK_BITS];
  // Security of the access must match the attribute of its block
  assign violation = up_req.valid && (attr_nonsec != up_req.nonsec);

endmodule
`default_nettype wire

//--- rtl/ssg_gate.sv
// SRAM security gate: configuration port, block table and memory gating
`timescale 1ns/10ps
`default_nettype none

module ssg_gate #(
  parameter int         ADDR_WIDTH      = 15,
  parameter logic [3:0] BLOCK_SIZE_CODE = 4'h0,
  parameter bit         GATING_OPTION   = 1'b1
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire ssg_pkg::ssg_apb_req_t apb_req,
  output var  ssg_pkg::ssg_apb_rsp_t apb_rsp,
  input  wire ssg_pkg::ssg_mem_req_t up_req,
  output logic                       up_ready,
  output var  ssg_pkg::ssg_mem_rsp_t up_rsp,
  output var  ssg_pkg::ssg_mem_req_t mem_req,
  input  wire logic                  mem_ready,
  input  wire ssg_pkg::ssg_mem_rsp_t mem_rsp,
  output logic                       violation_seen,
  output logic [31:0]                fault_addr
);

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int BLK_BITS  = int'(BLOCK_SIZE_CODE) + ssg_pkg::BLK_SHIFT_BASE;
  localparam int BLK_W     = ADDR_WIDTH - BLK_BITS;
  localparam int WORDS_LOG = BLK_W - ssg_pkg::WORD_LOG;
  localparam int WORDS     = 1 << WORDS_LOG;
  localparam int IDX_W     = (WORDS_LOG > 0) ? WORDS_LOG : 1;
  localparam bit AUTO_OK   = int'(BLOCK_SIZE_CODE) <= (ADDR_WIDTH - ssg_pkg::AUTO_MARGIN);
  localparam logic [31:0]      INDEX_LIMIT = 32'(WORDS - 1);
  localparam logic [IDX_W-1:0] IDX_LAST    = IDX_W'(WORDS - 1);

  typedef struct packed {
    logic             lock;
    logic             auto_inc;
    logic             gate_req;
    logic             gate_ack;
    logic             resp_err;
    logic [IDX_W-1:0] index;
    logic [31:0]      rdata;
    logic             mem_pending;
    logic             rsp_valid;
    logic             rsp_err;
    logic [31:0]      rsp_data;
    logic             seen;
    logic [31:0]      fault;
  } ssg_state_t;

  ssg_state_t       st;
  ssg_state_t       next_st;
  logic             setup;
  logic             access;
  logic             secure;
  logic             sel_ctrl;
  logic             sel_limit;
  logic             sel_geom;
  logic             sel_index;
  logic             sel_window;
  logic             cfg_write;
  logic             lut_wr_en;
  logic             auto_step;
  logic [31:0]      ctrl_image;
  logic [31:0]      ctrl_new;
  logic [31:0]      index_image;
  logic [31:0]      index_new;
  logic [31:0]      geom_image;
  logic [31:0]      lut_word;
  logic [IDX_W-1:0] idx_succ;
  logic [BLK_W-1:0] blk_num;
  logic             blk_nonsec;
  logic             viol;
  logic             path_free;
  logic             fwd_fire;
  logic             blk_fire;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Configuration port decode
  // ----------------------------------------------------------------
  assign setup      = apb_req.psel && !apb_req.penable;
  assign access     = apb_req.psel && apb_req.penable;
  assign secure     = !apb_req.pprot[ssg_pkg::PROT_NS];
  assign sel_ctrl   = apb_req.paddr[11:2] == ssg_pkg::OFS_CTRL[11:2];
  assign sel_limit  = apb_req.paddr[11:2] == ssg_pkg::OFS_LIMIT[11:2];
  assign sel_geom   = apb_req.paddr[11:2] == ssg_pkg::OFS_GEOM[11:2];
  assign sel_index  = apb_req.paddr[11:2] == ssg_pkg::OFS_INDEX[11:2];
  assign sel_window = apb_req.paddr[11:2] == ssg_pkg::OFS_WINDOW[11:2];
  // Non-secure writes never reach configuration state
  assign cfg_write  = ce && access && apb_req.pwrite && secure && !st.lock;
  assign lut_wr_en  = cfg_write && sel_window;
  assign auto_step  = ce && access && sel_window && st.auto_inc
                      && (!apb_req.pwrite
                          || (cfg_write && apb_req.pstrb == ssg_pkg::STRB_FULL));
  assign idx_succ   = (st.index == IDX_LAST) ? '0 : st.index + IDX_W'(1);

  always_comb
  begin
    ctrl_image = ssg_pkg::CTRL_RESET;
    ctrl_image[ssg_pkg::CTRL_LOCK] = st.lock;
    ctrl_image[ssg_pkg::CTRL_AUTO] = st.auto_inc;
    ctrl_image[ssg_pkg::CTRL_ACK]  = st.gate_ack;
    ctrl_image[ssg_pkg::CTRL_REQ]  = st.gate_req;
    ctrl_image[ssg_pkg::CTRL_RESP] = st.resp_err;
  end

  assign index_image = 32'(st.index);
  assign geom_image  = 32'(BLOCK_SIZE_CODE);
  assign ctrl_new    = merge_bytes(ctrl_image, apb_req.pwdata, apb_req.pstrb);
  assign index_new   = merge_bytes(index_image, apb_req.pwdata, apb_req.pstrb);

  // ----------------------------------------------------------------
  // Memory-side gating
  // ----------------------------------------------------------------
  // Traffic stays held until the acknowledge has dropped as well
  assign path_free = ce && !st.gate_req && !st.gate_ack && !st.mem_pending;
  assign fwd_fire  = path_free && up_req.valid && !viol && mem_ready;
  assign blk_fire  = path_free && viol;

  always_comb
  begin
    mem_req       = up_req;
    mem_req.valid = path_free && up_req.valid && !viol;
  end

  assign up_ready = path_free && (viol || mem_ready);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      // Read data is latched in the setup phase, any security level
      if (setup)
      begin
        next_st.rdata = ssg_pkg::RSP_ZERO;
        if (!apb_req.pwrite)
        begin
          if (sel_ctrl)
          begin
            next_st.rdata = ctrl_image;
          end
          if (sel_limit)
          begin
            next_st.rdata = INDEX_LIMIT;
          end
          if (sel_geom)
          begin
            next_st.rdata = geom_image;
          end
          if (sel_index)
          begin
            next_st.rdata = index_image;
          end
          if (sel_window)
          begin
            next_st.rdata = lut_word;
          end
        end
      end
      if (cfg_write && sel_ctrl)
      begin
        next_st.lock     = ctrl_new[ssg_pkg::CTRL_LOCK];
        next_st.auto_inc = AUTO_OK && ctrl_new[ssg_pkg::CTRL_AUTO];
        next_st.gate_req = GATING_OPTION && ctrl_new[ssg_pkg::CTRL_REQ];
        next_st.resp_err = ctrl_new[ssg_pkg::CTRL_RESP];
      end
      if (cfg_write && sel_index)
      begin
        next_st.index = index_new[IDX_W-1:0];
      end
      if (auto_step)
      begin
        next_st.index = idx_succ;
      end
      // Acknowledge once no forwarded access is outstanding
      next_st.gate_ack = GATING_OPTION && st.gate_req && !st.mem_pending;
      if (fwd_fire)
      begin
        next_st.mem_pending = 1'b1;
      end
      else if (mem_rsp.rvalid)
      begin
        next_st.mem_pending = 1'b0;
      end
      next_st.rsp_valid = 1'b0;
      if (mem_rsp.rvalid)
      begin
        next_st.rsp_valid = 1'b1;
        next_st.rsp_err   = mem_rsp.err;
        next_st.rsp_data  = mem_rsp.rdata;
      end
      if (blk_fire)
      begin
        next_st.rsp_valid = 1'b1;
        next_st.rsp_err   = st.resp_err;
        next_st.rsp_data  = ssg_pkg::RSP_ZERO;
      end
      if (blk_fire && !st.seen)
      begin
        next_st.seen  = 1'b1;
        next_st.fault = up_req.addr;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st          <= '0;
      st.lock     <= ssg_pkg::CTRL_RESET[ssg_pkg::CTRL_LOCK];
      st.auto_inc <= ssg_pkg::CTRL_RESET[ssg_pkg::CTRL_AUTO];
      st.gate_req <= ssg_pkg::CTRL_RESET[ssg_pkg::CTRL_REQ];
      st.resp_err <= ssg_pkg::CTRL_RESET[ssg_pkg::CTRL_RESP];
      st.index    <= ssg_pkg::INDEX_RESET[IDX_W-1:0];
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and submodules
  // ----------------------------------------------------------------
  always_comb
  begin
    apb_rsp.pready  = ce;
    apb_rsp.pslverr = access && apb_req.pwrite && !secure
                      && (sel_ctrl || sel_index || sel_window);
    apb_rsp.prdata  = st.rdata;
    up_rsp.rvalid   = st.rsp_valid;
    up_rsp.err      = st.rsp_err;
    up_rsp.rdata    = st.rsp_data;
  end

  assign violation_seen = st.seen;
  assign fault_addr     = st.fault;

  ssg_lut #(
    .WORDS (WORDS),
    .IDX_W (IDX_W),
    .BLK_W (BLK_W)
  ) u_lut (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .ce         (ce),
    .wr_en      (lut_wr_en),
    .wr_idx     (st.index),
    .wr_data    (apb_req.pwdata),
    .wr_strb    (apb_req.pstrb),
    .rd_idx     (st.index),
    .rd_word    (lut_word),
    .blk_num    (blk_num),
    .blk_nonsec (blk_nonsec)
  );

  ssg_check #(
    .ADDR_WIDTH (ADDR_WIDTH),
    .BLK_BITS   (BLK_BITS),
    .BLK_W      (BLK_W)
  ) u_check (
    .up_req      (up_req),
    .attr_nonsec (blk_nonsec),
    .blk_num     (blk_num),
    .violation   (viol)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_blocked;
    blk_fire;
  endsequence

  sequence s_gate_idle;
    ce && st.gate_req && !st.mem_pending;
  endsequence

  sequence s_window_read;
    ce && access && sel_window && st.auto_inc && !apb_req.pwrite;
  endsequence

  a_block_gate: assert property (viol |-> !mem_req.valid)
    else $error("violating access reached memory");

  a_blocked_answer: assert property (s_blocked |=> up_rsp.rvalid
      && up_rsp.rdata == ssg_pkg::RSP_ZERO && up_rsp.err == $past(st.resp_err))
    else $error("blocked access answered wrongly");

  a_ns_refused: assert property (ce && access && apb_req.pwrite && !secure
      && sel_ctrl |=> $stable({st.lock, st.auto_inc, st.gate_req, st.resp_err}))
    else $error("non-secure write changed control");

  a_ns_error: assert property (access && apb_req.pwrite && !secure && sel_window
      |-> apb_rsp.pslverr)
    else $error("non-secure write not refused");

  a_auto_step: assert property (s_window_read |=> st.index == $past(idx_succ))
    else $error("index did not advance");

  a_gate_ack: assert property (s_gate_idle |=> st.gate_ack)
    else $error("gating not acknowledged");

  a_ack_quiet: assert property (st.gate_ack |-> !mem_req.valid && !up_ready)
    else $error("traffic while gated");

  a_limit_read: assert property (ce && setup && sel_limit && !apb_req.pwrite
      |=> apb_rsp.prdata == INDEX_LIMIT)
    else $error("index limit read wrong");

  a_reserved_zero: assert property (ce && setup && sel_ctrl |=> apb_rsp.prdata[30:9] == '0
      && apb_rsp.prdata[5] == 1'b0 && apb_rsp.prdata[3:0] == '0)
    else $error("reserved control bit set");

  a_lock_hold: assert property (st.lock |=> st.lock)
    else $error("lockdown dropped");

  a_byte_strobe: assert property (cfg_write && sel_ctrl && !apb_req.pstrb[0]
      |=> st.resp_err == $past(st.resp_err))
    else $error("unstrobed byte written");

  a_fault_record: assert property (blk_fire && !st.seen
      |=> st.seen && st.fault == $past(up_req.addr))
    else $error("violation not recorded");

endmodule
`default_nettype wire

//--- bench/ssg_mem_model.sv
// Behavioural SRAM behind the gate, one access at a time, prompt or slow
`timescale 1ns/10ps
`default_nettype none

module ssg_mem_model (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  slow,
  input  wire ssg_pkg::ssg_mem_req_t mem_req,
  output logic                       mem_ready,
  output var  ssg_pkg::ssg_mem_rsp_t mem_rsp
);
  logic [31:0] mem [0:63];
  logic [31:0] last;
  logic [2:0]  wait_cnt;
  logic        busy;
  logic        stall;

  // Slow mode refuses every other cycle and answers late
  assign mem_ready = !busy && !(slow && stall);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      busy     <= 1'b0;
      wait_cnt <= 3'h0;
      stall    <= 1'b1;
      last     <= 32'h0000_0000;
      mem_rsp  <= '0;
    end
    else
    begin
      stall <= ~stall;
      // Idle data lines never repeat the last answer
      if (busy && wait_cnt == 3'h0)
        mem_rsp <= '{rvalid: 1'b1, err: 1'b0, rdata: last};
      else
        mem_rsp <= '{rvalid: 1'b0, err: 1'b0, rdata: ~last};
      if (mem_req.valid && mem_ready)
      begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 3'h3 : 3'h0;
        if (mem_req.write)
          mem[mem_req.addr[7:2]] <= mem_req.wdata;
        last <= mem_req.write ? mem_req.wdata : mem[mem_req.addr[7:2]];
      end
      else if (busy)
      begin
        if (wait_cnt == 3'h0)
          busy <= 1'b0;
        else
          wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule

`default_nettype wire

//--- bench/ssg_gate_tb_top.sv
// Self-checking bench of the SRAM security gate
`timescale 1ns/10ps
`default_nettype none

module ssg_gate_tb_top;
  logic                  ref_clk;
  logic                  nrst;
  logic                  ce;
  logic                  slow;
  ssg_pkg::ssg_apb_req_t apb_req;
  ssg_pkg::ssg_apb_rsp_t apb_rsp;
  ssg_pkg::ssg_mem_req_t up_req;
  logic                  up_ready;
  ssg_pkg::ssg_mem_rsp_t up_rsp;
  ssg_pkg::ssg_mem_req_t mem_req;
  logic                  mem_ready;
  ssg_pkg::ssg_mem_rsp_t mem_rsp;
  logic                  violation_seen;
  logic [31:0]           fault_addr;
  int                    error_cnt;
  int                    cmp_count;

  ssg_gate DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .up_req(up_req), .up_ready(up_ready), .up_rsp(up_rsp),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp),
    .violation_seen(violation_seen), .fault_addr(fault_addr));

  ssg_mem_model MEM (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rsp(mem_rsp));

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Configuration port transfers, zero wait states
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [2:0] p, output logic [31:0] rd,
                     output logic er);
    @(negedge ref_clk);
    apb_req = '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s,
                pprot: p};
    @(negedge ref_clk);
    apb_req.penable = 1'b1;
    @(posedge ref_clk);
    chk1("pready", 1'b1, apb_rsp.pready);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    @(negedge ref_clk);
    apb_req.psel    = 1'b0;
    apb_req.penable = 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [2:0] p, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0000_0000, 4'h0, p, rd, er);
    chk32("prdata", exp, rd);
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [2:0] p, input logic exp_err);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, s, p, rd, er);
    chk1("pslverr", exp_err, er);
  endtask

  // ----------------------------------------------------------------
  // Upstream memory transfers
  // ----------------------------------------------------------------
  task automatic mem_start(input logic w, input logic ns, input logic [31:0] a,
                           input logic [31:0] d);
    @(negedge ref_clk);
    up_req = '{valid: 1'b1, write: w, nonsec: ns, addr: a, wdata: d};
  endtask

  task automatic mem_finish(input logic [31:0] exp_d, input logic exp_e);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (up_ready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge ref_clk);
    end
    chk1("up_ready", 1'b1, up_ready);
    @(negedge ref_clk);
    up_req.valid = 1'b0;
    up_req.wdata = ~up_req.wdata;
    n = 0;
    @(posedge ref_clk);
    while (up_rsp.rvalid !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge ref_clk);
    end
    chk1("up_rsp.rvalid", 1'b1, up_rsp.rvalid);
    if (!up_req.write)
      chk32("up_rsp.rdata", exp_d, up_rsp.rdata);
    chk1("up_rsp.err", exp_e, up_rsp.err);
  endtask

  task automatic mem(input logic w, input logic ns, input logic [31:0] a,
                     input logic [31:0] d, input logic [31:0] exp_d, input logic exp_e);
    mem_start(w, ns, a, d);
    mem_finish(exp_d, exp_e);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk   = 1'b0;
    nrst      = 1'b0;
    ce        = 1'b1;
    slow      = 1'b0;
    apb_req   = '0;
    up_req    = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    rd_chk(ssg_pkg::OFS_CTRL, 3'h0, 32'h0000_0000);
    rd_chk(ssg_pkg::OFS_LIMIT, 3'h2, 32'h0000_001f);
    rd_chk(ssg_pkg::OFS_GEOM, 3'h2, 32'h0000_0000);
    rd_chk(ssg_pkg::OFS_WINDOW, 3'h2, 32'h0000_0000);
    wr_chk(ssg_pkg::OFS_CTRL, 32'h0000_0010, 4'hf, 3'h2, 1'b1);
    rd_chk(ssg_pkg::OFS_CTRL, 3'h0, 32'h0000_0000);
    wr_chk(12'h01b, 32'h0000_0000, 4'hf, 3'h0, 1'b0);
    wr_chk(12'h01e, 32'haabb_ccfe, 4'h5, 3'h0, 1'b0);
    rd_chk(ssg_pkg::OFS_WINDOW, 3'h0, 32'h00bb_00fe);
    // Block 0 secure, block 1 non-secure, 32-byte blocks
    mem(1'b1, 1'b0, 32'h0000_0000, 32'h1234_5678, 32'h0, 1'b0);
    mem(1'b0, 1'b0, 32'h0000_0000, 32'h0, 32'h1234_5678, 1'b0);
    slow = 1'b1;
    mem(1'b0, 1'b1, 32'h0000_001c, 32'h0, 32'h0000_0000, 1'b0);
    chk1("violation_seen", 1'b1, violation_seen);
    chk32("fault_addr", 32'h0000_001c, fault_addr);
    mem(1'b1, 1'b1, 32'h0000_0000, 32'hdead_beef, 32'h0, 1'b0);
    mem(1'b0, 1'b0, 32'h0000_0000, 32'h0, 32'h1234_5678, 1'b0);
    wr_chk(ssg_pkg::OFS_CTRL, 32'h0000_0010, 4'hf, 3'h0, 1'b0);
    mem(1'b1, 1'b0, 32'h0000_0020, 32'h0bad_0bad, 32'h0, 1'b1);
    mem(1'b1, 1'b1, 32'h0000_0020, 32'h5a5a_0f0f, 32'h0, 1'b0);
    mem(1'b0, 1'b1, 32'h0000_0020, 32'h0, 32'h5a5a_0f0f, 1'b0);
    mem(1'b0, 1'b1, 32'h0000_0000, 32'h0, 32'h0000_0000, 1'b1);
    chk32("fault_addr", 32'h0000_001c, fault_addr);
    // Auto-advance and wrap of the lookup index
    wr_chk(ssg_pkg::OFS_CTRL, 32'h0000_0110, 4'hf, 3'h0, 1'b0);
    wr_chk(ssg_pkg::OFS_INDEX, 32'h0000_001e, 4'hf, 3'h0, 1'b0);
    wr_chk(ssg_pkg::OFS_WINDOW, 32'h1111_1111, 4'hf, 3'h0, 1'b0);
    wr_chk(ssg_pkg::OFS_WINDOW, 32'h3333_3333, 4'h3, 3'h0, 1'b0);
    rd_chk(ssg_pkg::OFS_INDEX, 3'h0, 32'h0000_001f);
    wr_chk(ssg_pkg::OFS_WINDOW, 32'h2222_2222, 4'hf, 3'h0, 1'b0);
    rd_chk(ssg_pkg::OFS_INDEX, 3'h0, 32'h0000_0000);
    rd_chk(ssg_pkg::OFS_WINDOW, 3'h0, 32'h00bb_00fe);
    rd_chk(ssg_pkg::OFS_INDEX, 3'h0, 32'h0000_0001);
    // Reserved bits, gating request and acknowledge
    wr_chk(ssg_pkg::OFS_CTRL, 32'h7fff_ffff, 4'hf, 3'h0, 1'b0);
    rd_chk(ssg_pkg::OFS_CTRL, 3'h0, 32'h0000_01d0);
    mem_start(1'b0, 1'b0, 32'h0000_0000, 32'h0);
    repeat (3)
    begin
      @(posedge ref_clk);
      chk1("up_ready gated", 1'b0, up_ready);
    end
    wr_chk(ssg_pkg::OFS_CTRL, 32'h0000_0010, 4'hf, 3'h0, 1'b0);
    mem_finish(32'h1234_5678, 1'b0);
    rd_chk(ssg_pkg::OFS_CTRL, 3'h0, 32'h0000_0010);
    // Lockdown freezes configuration until reset
    wr_chk(ssg_pkg::OFS_CTRL, 32'h8000_0010, 4'hf, 3'h0, 1'b0);
    rd_chk(ssg_pkg::OFS_CTRL, 3'h2, 32'h8000_0010);
    wr_chk(ssg_pkg::OFS_CTRL, 32'h0000_0000, 4'hf, 3'h0, 1'b0);
    wr_chk(ssg_pkg::OFS_INDEX, 32'h0000_0005, 4'hf, 3'h0, 1'b0);
    rd_chk(ssg_pkg::OFS_CTRL, 3'h0, 32'h8000_0010);
    rd_chk(ssg_pkg::OFS_INDEX, 3'h0, 32'h0000_0001);
    // Reset clears lockdown, index and the recorded violation
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    rd_chk(ssg_pkg::OFS_CTRL, 3'h0, 32'h0000_0000);
    rd_chk(ssg_pkg::OFS_INDEX, 3'h0, 32'h0000_0000);
    chk1("violation_seen", 1'b0, violation_seen);
    finish_test();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    #50000;
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    finish_test();
  end
endmodule

`default_nettype wire
